// >>> logic/csg_pkg.sv
// Purpose: shared constants for the set/clear register block
// Assumes: 32-bit ahb-lite, one word per register
// Notes: addresses are word indices; byte address is four times the index
package csg_pkg;
    localparam logic [15:0] GMC_ADDR = 16'hff64;
    localparam logic [15:0] BUF_BASE = 16'hfa00;
    localparam logic [15:0] BUF_SPAN = 16'h0040;
    localparam logic [15:0] HIST_ADDR = 16'hff68;
    localparam logic [15:0] MODE_ADDR = 16'hff6c;
    localparam int BUF_COUNT = 16;
    localparam int BUF_WORDS = 4;
    localparam int SET_LSB = 8;
    localparam int GATE_BIT = 15;
    localparam int ARM_BIT = 1;
    localparam int ENABLE_BIT = 0;
    localparam int MODE_INIT_BIT = 0;
    localparam int MODE_SLEEP_BIT = 1;
    localparam int CTRL_WORD = 3;
    localparam logic [15:0] GMC_RESET = 16'h0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage

// >>> logic/csg_setclr.sv
// Purpose: one 8-bit register updated by paired set/clear request words
// Assumes: wr is a one-cycle strobe
// Notes: hardware set/clear inputs take priority over software
module csg_setclr (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wr,
    input wire logic [15:0] wdata,
    input wire logic [7:0] hw_set,
    input wire logic [7:0] hw_clr,
    output logic [7:0] q
);
    logic [7:0] next_q;
    always_comb begin
        next_q = q;
        if (wr) begin
            // set-only -> 1, clear-only -> 0, else hold
            next_q = (q | (wdata[15:8] & ~wdata[7:0]))
                & ~(wdata[7:0] & ~wdata[15:8]);
        end
        next_q = (next_q & ~hw_clr) | hw_set;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= 8'h00;
        end else begin
            q <= next_q;
        end
    end
endmodule

// >>> logic/csg_top.sv
// Purpose: global control register and message buffer store on ahb-lite
// Assumes: single word transfers, one clock, zero wait states
// Notes: mode inputs come from the protocol engine
// Notes on behaviour
// - write bits 15..8 request set, bits 7..0 request clear
// - set-only sets, clear-only clears, neither or both hold
// - paired registers read back their stored state; history returns only bits 7..0
// - paired scheme used by control-type registers, engine also changes
// - global control resets to zero: disabled, disarmed, gated
// - gate bit high permits buffer and history access
// - gate bit is read only to software
// - gate follows enable and sleep mode
// - enable set by write bit 8, cleared by bit 0
// - arm bit set by write bit 9, zero there clears it
// - armed clear of enable forces shutdown
// - any other access after arming drops the arm bit
// - enable clears only in init mode or right after arming
// - enable high lets module operate
// - sixteen buffers of eight data bytes, whole-word access only
//
// Design decision made here: the AHB-Lite interface to the registers.
module csg_top
    import csg_pkg::*;
#(
    parameter int NBUF = csg_pkg::BUF_COUNT
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic init_mode,
    input wire logic sleep_mode,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic module_enable,
    output logic forced_shutdown,
    output logic buffer_access_gate
);
    import csg_pkg::*;

    typedef enum logic [1:0] {
        CSG_IDLE,
        CSG_WRITE,
        CSG_READ
    } csg_phase_e;

    csg_phase_e phase, next_phase;
    logic [15:0] addr_q, next_addr_q;
    logic enable, next_enable;
    logic arm, next_arm;
    logic armed_last, next_armed_last;
    logic gate, next_gate;
    logic shut, next_shut;
    logic sleep_q, next_sleep_q;
    logic [31:0] rdata, next_rdata;
    logic [31:0] bufmem [NBUF*BUF_WORDS];
    logic [31:0] next_bufmem [NBUF*BUF_WORDS];
    logic [7:0] hist_q;
    logic hist_wr;
    logic take;
    logic [15:0] w16;
    logic [15:0] idx;

    function automatic logic in_buf(input logic [15:0] a);
        in_buf = (a >= BUF_BASE) && (a < BUF_BASE + BUF_SPAN);
    endfunction

    function automatic int buf_index(input logic [15:0] a);
        buf_index = int'(a[5:0]);
    endfunction

    assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign w16 = hwdata[15:0];
    // each register owns one word, so the two byte bits are dropped
    assign idx = haddr[17:2];
    assign hist_wr = (phase == CSG_WRITE) && (addr_q == HIST_ADDR) && gate;

    // history list stands in for every engine-shared paired register
    csg_setclr csg_setclr_i (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr(hist_wr),
        .wdata(w16),
        .hw_set(8'h00),
        .hw_clr(8'h00),
        .q(hist_q)
    );

    always_comb begin
        next_phase = CSG_IDLE;
        next_addr_q = addr_q;
        if (take) begin
            next_phase = hwrite ? CSG_WRITE : CSG_READ;
            next_addr_q = idx;
        end
    end

    // global control: write happens in data phase of the access
    always_comb begin
        next_enable = enable;
        next_arm = arm;
        next_armed_last = armed_last;
        next_shut = 1'b0;
        next_sleep_q = sleep_mode;
        if (phase == CSG_WRITE && addr_q == GMC_ADDR) begin
            next_armed_last = 1'b0;
            if (w16[SET_LSB+ENABLE_BIT] && !w16[ENABLE_BIT]) begin
                next_enable = 1'b1;
            end else if (!w16[SET_LSB+ENABLE_BIT] && w16[ENABLE_BIT]) begin
                if (init_mode || armed_last) begin
                    next_enable = 1'b0;
                    next_shut = armed_last;
                end
            end
            if (armed_last) begin
                next_arm = 1'b0;
            end
            if (w16[SET_LSB+ARM_BIT]) begin
                next_arm = 1'b1;
                next_armed_last = 1'b1;
            end
        end else if (phase != CSG_IDLE && arm) begin
            // any other access, read of this register too, drops the arm
            next_arm = 1'b0;
            next_armed_last = 1'b0;
        end
    end

    always_comb begin
        next_gate = gate;
        if (!enable || (sleep_mode && !sleep_q)) begin
            next_gate = 1'b0;
        end else if ((enable && !module_enable) ||
                     (!sleep_mode && sleep_q)) begin
            next_gate = 1'b1;
        end
    end

    // buffer word k: bytes 0-3, 4-7, length/config, identifier
    always_comb begin
        next_bufmem = bufmem;
        if (phase == CSG_WRITE && in_buf(addr_q) && gate) begin
            next_bufmem[buf_index(addr_q)] = hwdata;
            if (addr_q[1:0] == 2'(CTRL_WORD)) begin
                // control byte lives in bits 31:24 of word 3, paired scheme
                next_bufmem[buf_index(addr_q)][31:24] =
                    (bufmem[buf_index(addr_q)][31:24] |
                    (hwdata[15:8] & ~hwdata[7:0])) &
                    ~(hwdata[7:0] & ~hwdata[15:8]);
                next_bufmem[buf_index(addr_q)][23:0] =
                    bufmem[buf_index(addr_q)][23:0];
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (take && !hwrite) begin
            if (idx == GMC_ADDR) begin
                next_rdata = 32'(gate) << GATE_BIT;
                next_rdata[ARM_BIT] = arm;
                next_rdata[ENABLE_BIT] = enable;
            end else if (idx == HIST_ADDR) begin
                next_rdata = gate ? 32'(hist_q) : 32'h0000_0000;
            end else if (idx == MODE_ADDR) begin
                next_rdata[MODE_INIT_BIT] = init_mode;
                next_rdata[MODE_SLEEP_BIT] = sleep_mode;
            end else if (in_buf(idx) && gate) begin
                next_rdata = bufmem[buf_index(idx)];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= CSG_IDLE;
            addr_q <= 16'h0000;
            enable <= GMC_RESET[ENABLE_BIT];
            arm <= GMC_RESET[ARM_BIT];
            armed_last <= 1'b0;
            gate <= GMC_RESET[GATE_BIT];
            shut <= 1'b0;
            sleep_q <= 1'b0;
            rdata <= 32'h0000_0000;
            module_enable <= 1'b0;
            forced_shutdown <= 1'b0;
            buffer_access_gate <= 1'b0;
        end else begin
            phase <= next_phase;
            addr_q <= next_addr_q;
            enable <= next_enable;
            arm <= next_arm;
            armed_last <= next_armed_last;
            gate <= next_gate;
            shut <= next_shut;
            sleep_q <= next_sleep_q;
            rdata <= next_rdata;
            module_enable <= enable;
            forced_shutdown <= shut;
            buffer_access_gate <= gate;
        end
    end

    // buffer contents have no reset, as in the message ram
    always_ff @(posedge hclk) begin
        bufmem <= next_bufmem;
    end

    assign hrdata = rdata;
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    property p_arm_drop;
        @(posedge hclk) disable iff (!hresetn)
        (arm && phase == CSG_READ) |=> !arm;
    endproperty
    a_arm_drop: assert property (p_arm_drop)
        else $error("arm bit survived an intervening access");

    property p_enable_clear_guard;
        @(posedge hclk) disable iff (!hresetn)
        ($fell(enable)) |-> ($past(init_mode) || $past(armed_last));
    endproperty
    a_enable_clear_guard: assert property (p_enable_clear_guard)
        else $error("enable cleared outside init or armed access");

    property p_shutdown;
        @(posedge hclk) disable iff (!hresetn)
        (phase == CSG_WRITE && addr_q == GMC_ADDR && armed_last &&
         w16[ENABLE_BIT] && !w16[SET_LSB+ENABLE_BIT]) |-> ##2 forced_shutdown;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("armed clear of enable did not shut down");

    property p_gate_off;
        @(posedge hclk) disable iff (!hresetn)
        !enable |=> !gate;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("gate open while module disabled");

    property p_gated_read;
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && in_buf(idx) && !gate) |=> hrdata == 0;
    endproperty
    a_gated_read: assert property (p_gated_read)
        else $error("gated buffer read returned data");

    property p_enable_set;
        @(posedge hclk) disable iff (!hresetn)
        (phase == CSG_WRITE && addr_q == GMC_ADDR &&
         w16[SET_LSB+ENABLE_BIT] && !w16[ENABLE_BIT]) |=> ##1 module_enable;
    endproperty
    a_enable_set: assert property (p_enable_set)
        else $error("set request did not raise enable");

    property p_arm_set;
        @(posedge hclk) disable iff (!hresetn)
        (phase == CSG_WRITE && addr_q == GMC_ADDR &&
         w16[SET_LSB+ARM_BIT]) |=> arm;
    endproperty
    a_arm_set: assert property (p_arm_set)
        else $error("arm set request ignored");

    property p_gmc_read;
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && idx == GMC_ADDR) |=>
            hrdata == {16'h0000, $past(gate), 13'h0000, $past(arm),
                       $past(enable)};
    endproperty
    a_gmc_read: assert property (p_gmc_read)
        else $error("global control read mismatch");

    property p_enable_hold;
        @(posedge hclk) disable iff (!hresetn)
        (phase == CSG_WRITE && addr_q == GMC_ADDR &&
         w16[SET_LSB+ENABLE_BIT] == w16[ENABLE_BIT]) |=> $stable(enable);
    endproperty
    a_enable_hold: assert property (p_enable_hold)
        else $error("enable moved on a hold request");

    property p_gate_on;
        @(posedge hclk) disable iff (!hresetn)
        (enable && !module_enable && !sleep_mode) |=> gate;
    endproperty
    a_gate_on: assert property (p_gate_on)
        else $error("gate stayed shut after enable was set");

    property p_sleep_close;
        @(posedge hclk) disable iff (!hresetn)
        (sleep_mode && !sleep_q) |=> !gate;
    endproperty
    a_sleep_close: assert property (p_sleep_close)
        else $error("gate open after entering sleep");

    property p_wake_open;
        @(posedge hclk) disable iff (!hresetn)
        (enable && !sleep_mode && sleep_q) |=> gate;
    endproperty
    a_wake_open: assert property (p_wake_open)
        else $error("gate shut after leaving sleep");

    property p_hist_gated_write;
        @(posedge hclk) disable iff (!hresetn)
        (phase == CSG_WRITE && addr_q == HIST_ADDR && !gate) |=>
            $stable(hist_q);
    endproperty
    a_hist_gated_write: assert property (p_hist_gated_write)
        else $error("gated history write changed the register");

    property p_gated_hist_read;
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && idx == HIST_ADDR && !gate) |=>
            hrdata == 32'h0000_0000;
    endproperty
    a_gated_hist_read: assert property (p_gated_hist_read)
        else $error("gated history read returned data");

    property p_no_unarmed_shut;
        @(posedge hclk) disable iff (!hresetn)
        (phase == CSG_WRITE && addr_q == GMC_ADDR && !armed_last) |=>
            !shut;
    endproperty
    a_no_unarmed_shut: assert property (p_no_unarmed_shut)
        else $error("shutdown without a preceding arm write");

    property p_hist_hold;
        @(posedge hclk) disable iff (!hresetn)
        (hist_wr && w16[SET_LSB +: 8] == w16[7:0]) |=> $stable(hist_q);
    endproperty
    a_hist_hold: assert property (p_hist_hold)
        else $error("history changed on a hold request");

    property p_hist_set_all;
        @(posedge hclk) disable iff (!hresetn)
        (hist_wr && w16 == 16'hff00) |=> hist_q == 8'hff;
    endproperty
    a_hist_set_all: assert property (p_hist_set_all)
        else $error("set requests did not reach the history bits");

    property p_enable_out;
        @(posedge hclk) disable iff (!hresetn)
        module_enable == $past(enable);
    endproperty
    a_enable_out: assert property (p_enable_out)
        else $error("module enable output does not follow the bit");

    property p_shut_pulse;
        @(posedge hclk) disable iff (!hresetn)
        forced_shutdown |=> !forced_shutdown;
    endproperty
    a_shut_pulse: assert property (p_shut_pulse)
        else $error("shutdown pulse longer than one cycle");
endmodule

// >>> testbench/csg_top_test.sv
// Purpose: self-checking bench for the set/clear control block
// Assumes: one idle cycle between transfers, byte address is index times 4
// Notes: buffer ram is not reset, so it is read only while gated or after a write
module csg_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import csg_pkg::*;
    logic hclk, hresetn, hsel, hwrite, init_mode, sleep_mode;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, hresp;
    logic [2:0] hsize;
    logic hreadyout, module_enable, forced_shutdown, buffer_access_gate;
    logic [7:0] hist;
    logic [15:0] w;
    logic [31:0] mem [32];
    int num_errors, check_count, fs_count;

    csg_top csg_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .init_mode(init_mode),
        .sleep_mode(sleep_mode), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .module_enable(module_enable),
        .forced_shutdown(forced_shutdown),
        .buffer_access_gate(buffer_access_gate));

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // the pulse lasts one cycle, so count it on every edge
    always @(posedge hclk) begin
        if (forced_shutdown === 1'b1) fs_count++;
    end

    function automatic logic [7:0] setclr(logic [7:0] q, logic [15:0] d);
        return (q | (d[15:8] & ~d[7:0])) & ~(d[7:0] & ~d[15:8]);
    endfunction

    task automatic summarize;
        if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            num_errors++;
            $display("ERROR %0t bus wait timed out", $time);
            summarize();
        end
    endtask

    task automatic xfer(input logic wr, input logic [15:0] a,
                        input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {14'h0, a, 2'b00};
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        check({30'h0, hresp}, {30'h0, HRESP_OKAY}, "response");
        hsel <= 1'b0;
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, m);
        xfer(1'b0, a, 32'h0);
        check(rd & m, exp, "read data");
    endtask

    function automatic logic [15:0] baddr(int j);
        return BUF_BASE + 16'(j / 2 * BUF_WORDS + j % 2);
    endfunction

    initial begin
        {hresetn, hsel, hwrite, init_mode, sleep_mode} = 5'h00;
        {haddr, hwdata, htrans, hsize} = '0;
        num_errors = 0;
        check_count = 0;
        fs_count = 0;
        void'($urandom(32'hcac2));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        check({hreadyout, module_enable, buffer_access_gate}, 3'h4, "rst");
        rdchk(GMC_ADDR, 32'h0, 32'hffff);
        rdchk(baddr(0), 32'h0, 32'hffffffff);
        xfer(1'b1, GMC_ADDR, 32'h8000);
        rdchk(GMC_ADDR, 32'h0, 32'hffff);
        xfer(1'b1, GMC_ADDR, 32'h0100);
        repeat (3) @(posedge hclk);
        check({module_enable, buffer_access_gate}, 2'h3, "enable");
        rdchk(GMC_ADDR, 32'h8001, 32'hffff);
        for (int j = 0; j < 32; j++) begin
            mem[j] = (j == 0) ? 32'hffffffff : $urandom;
            xfer(1'b1, baddr(j), mem[j]);
        end
        for (int j = 0; j < 32; j++) rdchk(baddr(j), mem[j], '1);
        xfer(1'b1, BUF_BASE + 16'(CTRL_WORD), 32'hff00);
        xfer(1'b1, BUF_BASE + 16'(CTRL_WORD), 32'h0f0f);
        xfer(1'b1, BUF_BASE + 16'(CTRL_WORD), 32'h000f);
        rdchk(BUF_BASE + 16'(CTRL_WORD), 32'hf000_0000, 32'hff00_0000);
        xfer(1'b1, 16'hff70, 32'hffff);
        rdchk(16'hff70, 32'h0, '1);
        xfer(1'b1, GMC_ADDR, 32'h0001);
        rdchk(GMC_ADDR, 32'h8001, 32'hffff);
        xfer(1'b1, GMC_ADDR, 32'h0101);
        rdchk(GMC_ADDR, 32'h8001, 32'hffff);
        xfer(1'b1, GMC_ADDR, 32'h0200);
        rdchk(GMC_ADDR, 32'h8001, 32'h8001);
        xfer(1'b1, GMC_ADDR, 32'h0001);
        rdchk(GMC_ADDR, 32'h8001, 32'hffff);
        xfer(1'b1, GMC_ADDR, 32'h0200);
        xfer(1'b1, GMC_ADDR, 32'h0001);
        repeat (3) @(posedge hclk);
        check(32'(fs_count), 32'h1, "shutdown pulses");
        check({module_enable, buffer_access_gate}, 2'h0, "off");
        rdchk(GMC_ADDR, 32'h0, 32'h8001);
        xfer(1'b1, GMC_ADDR, 32'h0100);
        @(posedge hclk) init_mode <= 1'b1;
        xfer(1'b1, GMC_ADDR, 32'h0001);
        rdchk(GMC_ADDR, 32'h0, 32'h8001);
        check(32'(fs_count), 32'h1, "unarmed clear");
        @(posedge hclk) init_mode <= 1'b0;
        xfer(1'b1, GMC_ADDR, 32'h0100);
        hist = 8'h00;
        xfer(1'b1, HIST_ADDR, 32'h00ff);
        for (int i = 0; i < 40; i++) begin
            w = (i == 0) ? 16'hffff : (i == 1) ? 16'hff00 : 16'($urandom);
            hist = setclr(hist, w);
            xfer(1'b1, HIST_ADDR, {16'h0000, w});
            rdchk(HIST_ADDR, {24'h0, hist}, 32'hff);
        end
        @(posedge hclk) sleep_mode <= 1'b1;
        repeat (3) @(posedge hclk);
        check({31'h0, buffer_access_gate}, 32'h0, "sleep gate");
        xfer(1'b1, baddr(1), ~mem[1]);
        rdchk(baddr(1), 32'h0, '1);
        rdchk(HIST_ADDR, 32'h0, '1);
        xfer(1'b1, HIST_ADDR, {16'h0000, ~hist, hist});
        @(posedge hclk) sleep_mode <= 1'b0;
        repeat (3) @(posedge hclk);
        check({31'h0, buffer_access_gate}, 32'h1, "wake gate");
        rdchk(baddr(1), mem[1], '1);
        rdchk(HIST_ADDR, {24'h0, hist}, 32'hff);
        summarize();
    end
endmodule
